// *** hdl/accel_regs_pkg.sv ***
// Register map constants, reset values and carrier types for the accelerometer register bank.
package accel_regs_pkg;

	localparam int          AXIS_W      = 10;
	localparam int          OFFSET_W    = 11;
	localparam logic [7:0]  REG_COUNT   = 8'h20;

	localparam logic [7:0]  X_ACCEL_LOW         = 8'h00;
	localparam logic [7:0]  X_ACCEL_HIGH        = 8'h01;
	localparam logic [7:0]  Y_ACCEL_LOW         = 8'h02;
	localparam logic [7:0]  Y_ACCEL_HIGH        = 8'h03;
	localparam logic [7:0]  Z_ACCEL_LOW         = 8'h04;
	localparam logic [7:0]  Z_ACCEL_HIGH        = 8'h05;
	localparam logic [7:0]  X_ACCEL_BYTE        = 8'h06;
	localparam logic [7:0]  Y_ACCEL_BYTE        = 8'h07;
	localparam logic [7:0]  Z_ACCEL_BYTE        = 8'h08;
	localparam logic [7:0]  SAMPLE_STATUS       = 8'h09;
	localparam logic [7:0]  DETECTION_SOURCE    = 8'h0a;
	localparam logic [7:0]  TEMPERATURE_VALUE   = 8'h0b;
	localparam logic [7:0]  RESERVED_0C         = 8'h0c;
	localparam logic [7:0]  BUS_ADDRESS_CTRL    = 8'h0d;
	localparam logic [7:0]  USER_INFO           = 8'h0e;
	localparam logic [7:0]  IDENTITY_VALUE      = 8'h0f;
	localparam logic [7:0]  X_OFFSET_LOW        = 8'h10;
	localparam logic [7:0]  X_OFFSET_HIGH       = 8'h11;
	localparam logic [7:0]  Y_OFFSET_LOW        = 8'h12;
	localparam logic [7:0]  Y_OFFSET_HIGH       = 8'h13;
	localparam logic [7:0]  Z_OFFSET_LOW        = 8'h14;
	localparam logic [7:0]  Z_OFFSET_HIGH       = 8'h15;
	localparam logic [7:0]  OPERATING_MODE_CTRL = 8'h16;
	localparam logic [7:0]  IRQ_LATCH_CLEAR     = 8'h17;
	localparam logic [7:0]  DETECT_CTRL_A       = 8'h18;
	localparam logic [7:0]  DETECT_CTRL_B       = 8'h19;
	localparam logic [7:0]  LEVEL_THRESHOLD     = 8'h1a;
	localparam logic [7:0]  PULSE_THRESHOLD     = 8'h1b;
	localparam logic [7:0]  PULSE_DURATION      = 8'h1c;
	localparam logic [7:0]  PULSE_LATENCY       = 8'h1d;
	localparam logic [7:0]  SECOND_PULSE_WINDOW = 8'h1e;
	localparam logic [7:0]  RESERVED_1F         = 8'h1f;

	// Field positions and reset values.
	localparam int          BUS_DISABLE_BIT     = 7;
	localparam logic [6:0]  BUS_DEVICE_ADDR     = 7'h1d;
	localparam logic [7:0]  BYTE_RESET          = 8'h00;
	localparam logic [9:0]  AXIS_RESET          = 10'h000;
	localparam logic [10:0] OFFSET_RESET        = 11'h000;
	localparam logic [6:0]  MODE_RESET          = 7'h00;
	localparam logic [2:0]  CTRL_B_RESET        = 3'h0;
	localparam logic [1:0]  IRQ_CLEAR_RESET     = 2'h0;
	localparam logic [1:0]  HIGH_RESET          = 2'h0;

	typedef struct packed {
		logic [9:0] x;
		logic [9:0] y;
		logic [9:0] z;
		logic [7:0] x8;
		logic [7:0] y8;
		logic [7:0] z8;
	} sample_s;

	typedef struct packed {
		logic [10:0] x_offset;
		logic [10:0] y_offset;
		logic [10:0] z_offset;
		logic [6:0]  mode;
		logic [1:0]  irq_clear;
		logic [7:0]  detect_a;
		logic [2:0]  detect_b;
		logic [7:0]  level_thr;
		logic [7:0]  pulse_thr;
		logic [7:0]  pulse_dur;
		logic [7:0]  pulse_lat;
		logic [7:0]  pulse_window;
		logic        bus_disable;
	} ctrl_s;

endpackage

// *** hdl/accel_user_register_map.sv ***
// User register bank of a three-axis accelerometer with byte-wide auto-incrementing access.
// Notes on behaviour
// - X 10-bit result: low byte at one address, bits 9:8 in next register bits 1:0.
// - Y 10-bit result split the same way over its low and high registers.
// - Z 10-bit result split the same way over its low and high registers.
// - Reading X low byte captures X high bits for the following high read.
// - Reading Y or Z low byte likewise captures that axis's high bits.
// - Axis outputs are two's complement, zero acceleration reads all zeros.
// - Separate 8-bit X, Y, Z outputs follow at three consecutive addresses.
// - Writable signed 11-bit offset per axis, bits 10:8 in high register bits 2:0.
// - Writable 8-bit level-detection threshold.
// - Writable 8-bit pulse-detection threshold.
// - Register pointer advances by one after every byte read or written.
`timescale 1ns/1ps
module accel_user_register_map
	import accel_regs_pkg::*;
#(
	// Arbitrary values, not tied to any real part.
	parameter logic [7:0] USER_INFO_VALUE = 8'h00,
	parameter logic [7:0] IDENTITY_CODE   = 8'h5a
)
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	// Byte access port from the serial slave front end
	input  wire logic       addr_load_in,
	input  wire logic [7:0] addr_in,
	input  wire logic       rd_in,
	input  wire logic       wr_in,
	input  wire logic [7:0] wdata_in,
	output logic [7:0]      rdata_out,
	output logic            rdata_valid_out,
	output logic [7:0]      pointer_out,
	// Sensor side
	input  wire logic       sample_valid_in,
	input  wire sample_s    sample_in,
	input  wire logic [2:0] status_in,
	input  wire logic [7:0] detect_in,
	input  wire logic [7:0] temp_in,
	// Settings to the sensing logic
	output ctrl_s           ctrl_out
);

	sample_s     live_reg;
	logic [1:0]  x_high_reg;
	logic [1:0]  y_high_reg;
	logic [1:0]  z_high_reg;
	logic [7:0]  ptr_reg;
	logic [7:0]  rdata_reg;
	logic        rvalid_reg;
	ctrl_s       ctrl_reg;
	logic [7:0]  status_reg;
	logic [7:0]  detect_reg;
	logic [7:0]  temp_reg;
	logic        rd_go;
	logic        wr_go;

	// A pointer load takes the cycle; a byte strike in the same cycle is dropped.
	assign rd_go = rd_in && !addr_load_in;
	assign wr_go = wr_in && !addr_load_in;

	function automatic logic [7:0] high_byte(input logic [1:0] bits);
		high_byte = {6'h00, bits};
	endfunction

	function automatic logic [7:0] read_mux(input logic [7:0] a);
		read_mux = BYTE_RESET;
		case (a)
			X_ACCEL_LOW:         read_mux = live_reg.x[7:0];
			X_ACCEL_HIGH:        read_mux = high_byte(x_high_reg);
			Y_ACCEL_LOW:         read_mux = live_reg.y[7:0];
			Y_ACCEL_HIGH:        read_mux = high_byte(y_high_reg);
			Z_ACCEL_LOW:         read_mux = live_reg.z[7:0];
			Z_ACCEL_HIGH:        read_mux = high_byte(z_high_reg);
			X_ACCEL_BYTE:        read_mux = live_reg.x8;
			Y_ACCEL_BYTE:        read_mux = live_reg.y8;
			Z_ACCEL_BYTE:        read_mux = live_reg.z8;
			SAMPLE_STATUS:       read_mux = status_reg;
			DETECTION_SOURCE:    read_mux = detect_reg;
			TEMPERATURE_VALUE:   read_mux = temp_reg;
			BUS_ADDRESS_CTRL:    read_mux = {ctrl_reg.bus_disable, BUS_DEVICE_ADDR};
			USER_INFO:           read_mux = USER_INFO_VALUE;
			IDENTITY_VALUE:      read_mux = IDENTITY_CODE;
			X_OFFSET_LOW:        read_mux = ctrl_reg.x_offset[7:0];
			X_OFFSET_HIGH:       read_mux = {5'h00, ctrl_reg.x_offset[10:8]};
			Y_OFFSET_LOW:        read_mux = ctrl_reg.y_offset[7:0];
			Y_OFFSET_HIGH:       read_mux = {5'h00, ctrl_reg.y_offset[10:8]};
			Z_OFFSET_LOW:        read_mux = ctrl_reg.z_offset[7:0];
			Z_OFFSET_HIGH:       read_mux = {5'h00, ctrl_reg.z_offset[10:8]};
			OPERATING_MODE_CTRL: read_mux = {1'b0, ctrl_reg.mode};
			IRQ_LATCH_CLEAR:     read_mux = {6'h00, ctrl_reg.irq_clear};
			DETECT_CTRL_A:       read_mux = ctrl_reg.detect_a;
			DETECT_CTRL_B:       read_mux = {5'h00, ctrl_reg.detect_b};
			LEVEL_THRESHOLD:     read_mux = ctrl_reg.level_thr;
			PULSE_THRESHOLD:     read_mux = ctrl_reg.pulse_thr;
			PULSE_DURATION:      read_mux = ctrl_reg.pulse_dur;
			PULSE_LATENCY:       read_mux = ctrl_reg.pulse_lat;
			SECOND_PULSE_WINDOW: read_mux = ctrl_reg.pulse_window;
			default:             read_mux = BYTE_RESET;
		endcase
	endfunction

	// Live sample; values arrive already in two's complement.
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			live_reg <= '0;
		end
		else if (sample_valid_in)
		begin
			// stored unchanged, zero is all zeros
			live_reg <= sample_in;
		end
	end

	// Status, detection and temperature pass through one register stage.
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			status_reg <= BYTE_RESET;
			detect_reg <= BYTE_RESET;
			temp_reg   <= BYTE_RESET;
		end
		else
		begin
			status_reg <= {5'h00, status_in};
			detect_reg <= detect_in;
			temp_reg   <= temp_in;
		end
	end

	// High bits freeze on a low-byte read so a later sample cannot tear the pair.
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			x_high_reg <= HIGH_RESET;
			y_high_reg <= HIGH_RESET;
			z_high_reg <= HIGH_RESET;
		end
		else if (rd_go)
		begin
			if (ptr_reg == X_ACCEL_LOW)
				x_high_reg <= live_reg.x[9:8];
			// Y and Z capture on low read
			if (ptr_reg == Y_ACCEL_LOW)
				y_high_reg <= live_reg.y[9:8];
			if (ptr_reg == Z_ACCEL_LOW)
				z_high_reg <= live_reg.z[9:8];
		end
	end

	// Pointer load and auto increment.
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ptr_reg <= BYTE_RESET;
		end
		else if (addr_load_in)
		begin
			ptr_reg <= addr_in;
		end
		else if (rd_go || wr_go)
		begin
			ptr_reg <= ptr_reg + 8'h01;
		end
	end

	// Read data stage.
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rdata_reg  <= BYTE_RESET;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rvalid_reg <= rd_go;
			if (rd_go)
				rdata_reg <= read_mux(ptr_reg);
		end
	end

	// Writable settings; writes to read-only or reserved addresses fall through.
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ctrl_reg.x_offset     <= OFFSET_RESET;
			ctrl_reg.y_offset     <= OFFSET_RESET;
			ctrl_reg.z_offset     <= OFFSET_RESET;
			ctrl_reg.mode         <= MODE_RESET;
			ctrl_reg.irq_clear    <= IRQ_CLEAR_RESET;
			ctrl_reg.detect_a     <= BYTE_RESET;
			ctrl_reg.detect_b     <= CTRL_B_RESET;
			ctrl_reg.level_thr    <= BYTE_RESET;
			ctrl_reg.pulse_thr    <= BYTE_RESET;
			ctrl_reg.pulse_dur    <= BYTE_RESET;
			ctrl_reg.pulse_lat    <= BYTE_RESET;
			ctrl_reg.pulse_window <= BYTE_RESET;
			ctrl_reg.bus_disable  <= 1'b0;
		end
		else if (wr_go)
		begin
			case (ptr_reg)
				BUS_ADDRESS_CTRL:    ctrl_reg.bus_disable <= wdata_in[BUS_DISABLE_BIT];
				// offsets, high register keeps bits 2:0
				X_OFFSET_LOW:        ctrl_reg.x_offset[7:0]  <= wdata_in;
				X_OFFSET_HIGH:       ctrl_reg.x_offset[10:8] <= wdata_in[2:0];
				Y_OFFSET_LOW:        ctrl_reg.y_offset[7:0]  <= wdata_in;
				Y_OFFSET_HIGH:       ctrl_reg.y_offset[10:8] <= wdata_in[2:0];
				Z_OFFSET_LOW:        ctrl_reg.z_offset[7:0]  <= wdata_in;
				Z_OFFSET_HIGH:       ctrl_reg.z_offset[10:8] <= wdata_in[2:0];
				OPERATING_MODE_CTRL: ctrl_reg.mode      <= wdata_in[6:0];
				IRQ_LATCH_CLEAR:     ctrl_reg.irq_clear <= wdata_in[1:0];
				DETECT_CTRL_A:       ctrl_reg.detect_a  <= wdata_in;
				DETECT_CTRL_B:       ctrl_reg.detect_b  <= wdata_in[2:0];
				LEVEL_THRESHOLD:     ctrl_reg.level_thr <= wdata_in;
				PULSE_THRESHOLD:     ctrl_reg.pulse_thr <= wdata_in;
				PULSE_DURATION:      ctrl_reg.pulse_dur <= wdata_in;
				PULSE_LATENCY:       ctrl_reg.pulse_lat <= wdata_in;
				SECOND_PULSE_WINDOW: ctrl_reg.pulse_window <= wdata_in;
				default:             ctrl_reg.detect_b  <= ctrl_reg.detect_b;
			endcase
		end
	end

	assign rdata_out       = rdata_reg;
	assign rdata_valid_out = rvalid_reg;
	assign pointer_out     = ptr_reg;
	assign ctrl_out        = ctrl_reg;

	sequence rd_at(logic [7:0] a);
		rd_go && (ptr_reg == a);
	endsequence

	sequence wr_at(logic [7:0] a);
		wr_go && (ptr_reg == a);
	endsequence

	read_answer_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_go |=> rdata_valid_out ##1 (rdata_valid_out == $past(rd_go)))
		else $error("read data valid not one cycle after read");

	ptr_step_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(rd_go || wr_go) |=> (ptr_reg == $past(ptr_reg) + 8'h01))
		else $error("pointer did not advance by one");

	x_low_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_at(X_ACCEL_LOW) |=> (rdata_out == $past(live_reg.x[7:0])))
		else $error("x low byte read wrong");

	x_pair_coherent_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(rd_at(X_ACCEL_LOW) ##1 rd_at(X_ACCEL_HIGH)) |=>
		(rdata_out == {6'h00, $past(live_reg.x[9:8], 2)}))
		else $error("x high byte not from captured sample");

	y_capture_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_at(Y_ACCEL_LOW) |=> (y_high_reg == $past(live_reg.y[9:8])))
		else $error("y high bits not captured");

	z_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!(rd_go && (ptr_reg == Z_ACCEL_LOW)) |=> $stable(z_high_reg))
		else $error("z captured high bits changed without low read");

	reserved_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(rd_go && (ptr_reg == RESERVED_0C || ptr_reg == RESERVED_1F || ptr_reg >= REG_COUNT))
		|=> (rdata_out == 8'h00))
		else $error("reserved address read nonzero");

	offset_high_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_at(X_OFFSET_HIGH) |=> (ctrl_out.x_offset[10:8] == $past(wdata_in[2:0]))
		&& (ctrl_out.x_offset[7:0] == $past(ctrl_out.x_offset[7:0])))
		else $error("x offset high write wrong");

	thresholds_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_at(LEVEL_THRESHOLD) |=> (ctrl_out.level_thr == $past(wdata_in))
		&& (ctrl_out.pulse_thr == $past(ctrl_out.pulse_thr)))
		else $error("level threshold write wrong");

	pulse_thr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_at(PULSE_THRESHOLD) |=> (ctrl_out.pulse_thr == $past(wdata_in)))
		else $error("pulse threshold write wrong");

	ptr_load_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		addr_load_in |=> (ptr_reg == $past(addr_in)))
		else $error("pointer load wrong");

	y_low_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_at(Y_ACCEL_LOW) |=> (rdata_out == $past(live_reg.y[7:0])))
		else $error("y low byte read wrong");

	z_low_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_at(Z_ACCEL_LOW) |=> (rdata_out == $past(live_reg.z[7:0])))
		else $error("z low byte read wrong");

	z_capture_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_at(Z_ACCEL_LOW) |=> (z_high_reg == $past(live_reg.z[9:8])))
		else $error("z high bits not captured");

	x_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!(rd_go && (ptr_reg == X_ACCEL_LOW)) |=> $stable(x_high_reg))
		else $error("x captured high bits changed without low read");

	y_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!(rd_go && (ptr_reg == Y_ACCEL_LOW)) |=> $stable(y_high_reg))
		else $error("y captured high bits changed without low read");

	byte_out_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_at(X_ACCEL_BYTE) |=> (rdata_out == $past(live_reg.x8)))
		else $error("x byte output read wrong");

	high_unused_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_at(X_ACCEL_HIGH) |=> (rdata_out[7:2] == 6'h00))
		else $error("x high byte unused bits nonzero");

	sample_store_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		sample_valid_in |=> (live_reg == $past(sample_in)))
		else $error("sample not stored unchanged");

	status_unused_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		rd_at(SAMPLE_STATUS) |=> (rdata_out[7:3] == 5'h00))
		else $error("status unused bits nonzero");

	offset_low_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_at(X_OFFSET_LOW) |=> (ctrl_out.x_offset[7:0] == $past(wdata_in)))
		else $error("x offset low write wrong");

endmodule

// *** tb/accel_user_register_map_test.sv ***
// Self-checking bench for the accelerometer register bank.
`timescale 1ns/1ps
module accel_user_register_map_test;
	import accel_regs_pkg::*;

	// Arbitrary values, not tied to any real part.
	localparam logic [7:0] UI_VAL  = 8'h11;
	localparam logic [7:0] ID_CODE = 8'h3c;

	logic        clk_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic        addr_load, rd, wr, rvalid, sv = 1'b0;
	logic [7:0]  addr, wdata, rdata, ptr, d, d2;
	logic [2:0]  status = 3'h5;
	logic [7:0]  detect = 8'hc3;
	logic [7:0]  temp = 8'h9a;
	sample_s     samp = '0;
	ctrl_s       ctrl;
	int          err_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	logic [9:0]  s1 [3] = '{10'h2b4, 10'h17f, 10'h301};
	logic [9:0]  s2 [3] = '{10'h1c3, 10'h2aa, 10'h0ff};
	logic [7:0]  bytes [6] = '{8'h81, 8'h7e, 8'h00, 8'h05, 8'hc3, 8'h9a};
	// Rows: address, byte written, byte read back.
	logic [23:0] rows [20] = '{24'h10fdfd, 24'h103434, 24'h11fd05, 24'h128080, 24'h13ff07,
		24'h14aaaa, 24'h15f800, 24'h16ff7f, 24'h17ff03, 24'h18ffff, 24'h19ff07,
		24'h1aa5a5, 24'h1b5a5a, 24'h1e6969, 24'h0dff9d, 24'h00ff00, 24'h0bff9a,
		24'h0cff00, 24'h1fff00, 24'h20ff00};

	always #25 clk_in = ~clk_in;

	accel_user_register_map #(.USER_INFO_VALUE(UI_VAL), .IDENTITY_CODE(ID_CODE)) i_dut (
		.clk_in(clk_in), .nrst_in(nrst_in), .addr_load_in(addr_load), .addr_in(addr),
		.rd_in(rd), .wr_in(wr), .wdata_in(wdata), .rdata_out(rdata),
		.rdata_valid_out(rvalid), .pointer_out(ptr), .sample_valid_in(sv),
		.sample_in(samp), .status_in(status), .detect_in(detect), .temp_in(temp),
		.ctrl_out(ctrl));

	host_model i_host (
		.clk_in(clk_in), .rdata_in(rdata), .rdata_valid_in(rvalid),
		.addr_load_out(addr_load), .addr_out(addr), .rd_out(rd), .wr_out(wr),
		.wdata_out(wdata));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("Compares %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic put(input int sel);
		@(posedge clk_in);
		if (sel == 1)
			samp <= sample_s'{x: s1[0], y: s1[1], z: s1[2], x8: 8'h81, y8: 8'h7e, z8: 8'h00};
		else
			samp <= sample_s'{x: s2[0], y: s2[1], z: s2[2], x8: 8'h18, y8: 8'he7, z8: 8'hff};
		sv <= 1'b1;
		@(posedge clk_in);
		sv <= 1'b0;
	endtask

	function automatic logic [7:0] rst_val(input logic [7:0] a);
		case (a)
			BUS_ADDRESS_CTRL: return {1'b0, BUS_DEVICE_ADDR};
			USER_INFO:        return UI_VAL;
			IDENTITY_VALUE:   return ID_CODE;
			SAMPLE_STATUS:    return {5'h00, status};
			DETECTION_SOURCE: return detect;
			TEMPERATURE_VALUE: return temp;
			default:          return BYTE_RESET;
		endcase
	endfunction

	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			stop_test();
		end
	end

	initial
	begin
		repeat (16) @(posedge clk_in);
		nrst_in <= 1'b1;
		i_host.load(8'h00);
		for (int a = 0; a < 32; a++)
		begin
			i_host.rd(d);
			chk(d, rst_val(a[7:0]));
		end
		foreach (rows[i])
		begin
			i_host.load(rows[i][23:16]);
			i_host.wr(rows[i][15:8]);
			i_host.load(rows[i][23:16]);
			i_host.rd(d);
			chk(d, rows[i][7:0]);
		end
		chk(ctrl.x_offset, 11'h534);
		chk(ctrl.level_thr, 8'ha5);
		chk(ctrl.pulse_thr, 8'h5a);
		i_host.load(PULSE_DURATION);
		i_host.wr(8'h11);
		i_host.wr(8'h22);
		chk({ctrl.pulse_dur, ctrl.pulse_lat}, 16'h1122);
		chk(ptr, 8'h1e);
		for (int i = 0; i < 3; i++)
		begin
			put(1);
			i_host.load(8'(2 * i));
			i_host.rd(d);
			chk(d, s1[i][7:0]);
			put(2);
			// The high byte follows its low byte with no other access between.
			i_host.rd(d);
			chk(d, {6'h00, s1[i][9:8]});
		end
		put(1);
		i_host.load(X_ACCEL_LOW);
		i_host.rd2(d, d2);
		chk({d2, d}, {6'h00, s1[0]});
		i_host.load(X_ACCEL_BYTE);
		for (int i = 0; i < 6; i++)
		begin
			i_host.rd(d);
			chk(d, bytes[i]);
		end
		i_host.load(8'hff);
		i_host.rd(d);
		chk({d, ptr}, 16'h0000);
		@(posedge clk_in);
		nrst_in <= 1'b0;
		#1;
		chk({ctrl.level_thr, ptr}, 16'h0000);
		@(posedge clk_in);
		nrst_in <= 1'b1;
		i_host.load(Y_ACCEL_HIGH);
		i_host.rd(d);
		chk(d, 8'h00);
		stop_test();
	end
endmodule

// *** tb/host_model.sv ***
// Host model that loads the register pointer and reads or writes single bytes.
`timescale 1ns/1ps
module host_model
(
	// Clock
	input  wire logic       clk_in,
	// Answers from the register bank
	input  wire logic [7:0] rdata_in,
	input  wire logic       rdata_valid_in,
	// Requests to the register bank
	output logic            addr_load_out,
	output logic [7:0]      addr_out,
	output logic            rd_out,
	output logic            wr_out,
	output logic [7:0]      wdata_out
);
	initial
	begin
		addr_load_out = 1'b0;
		addr_out = 8'h00;
		rd_out = 1'b0;
		wr_out = 1'b0;
		wdata_out = 8'h00;
	end

	// Released fields carry the inverse so stale values cannot pass.
	task automatic load(input logic [7:0] a);
		@(posedge clk_in);
		addr_load_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		addr_load_out <= 1'b0;
		addr_out <= ~a;
	endtask

	// An answer not flagged valid comes back inverted so it cannot match.
	task automatic rd(output logic [7:0] d);
		@(posedge clk_in);
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1;
		d = (rdata_valid_in === 1'b1) ? rdata_in : ~rdata_in;
	endtask

	task automatic wr(input logic [7:0] d);
		@(posedge clk_in);
		wr_out <= 1'b1;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
		#1;
	endtask

	// Two reads on consecutive edges, as a host does for a coherent pair.
	task automatic rd2(output logic [7:0] d0, output logic [7:0] d1);
		@(posedge clk_in);
		rd_out <= 1'b1;
		@(posedge clk_in);
		#1;
		d0 = (rdata_valid_in === 1'b1) ? rdata_in : ~rdata_in;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1;
		d1 = (rdata_valid_in === 1'b1) ? rdata_in : ~rdata_in;
	endtask
endmodule
